/* logic/address_generation_unit.v */
`timescale 1ns/1ps
`include "agu_defs.vh"

module address_generation_unit #(
  parameter NUM_SEGS = 6,
  parameter SEG_SEL_W = 3
) (
  input  wire                 ref_clk,
  input  wire                 rstn,
  input  wire [1:0]           opMode,
  input  wire                 pagingOn,
  input  wire                 reqValid,
  input  wire                 reqIsIo,
  input  wire [2:0]           baseSel,
  input  wire [2:0]           indexSel,
  input  wire                 useBase,
  input  wire                 useIndex,
  input  wire                 useDisp,
  input  wire [1:0]           scaleMultiplier,
  input  wire [31:0]          instructionDisplacement,
  input  wire [1:0]           accessSize,
  input  wire [SEG_SEL_W-1:0] segSel,
  input  wire [255:0]         genRegFile,
  input  wire                 segWrite,
  input  wire [SEG_SEL_W-1:0] segWriteSel,
  input  wire [15:0]          segWriteValue,
  input  wire [31:0]          globalDescriptorTable,
  input  wire [31:0]          localDescriptorTable,
  input  wire                 descValid,
  input  wire [63:0]          descData,
  input  wire                 xlateDone,
  input  wire [19:0]          xlateFrame,
  output reg                  busy,
  output reg                  addrValid,
  output reg                  isIoAccess,
  output reg  [31:0]          physAddr,
  output reg  [3:0]           byteEnable,
  output reg                  crossesDword,
  output reg  [31:0]          effectiveOffset,
  output reg  [31:0]          linearAddr,
  output reg                  xlateReq,
  output reg                  descReq,
  output reg  [31:0]          descAddr
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_PAGE = 2'h1;
  localparam [1:0] ST_DESC = 2'h2;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------

  // Pick one 32-bit general register out of the flattened file
  function [31:0] pickReg;
    input [255:0] file;
    input [2:0]   code;
    begin
      pickReg = file[code*32 +: 32];
    end
  endfunction

  // Shift index left by the scale code: 1, 2, 4 or 8
  function [31:0] scaleIndex;
    input [31:0] value;
    input [1:0]  code;
    begin
      case (code)
        2'h0:    scaleIndex = value;
        2'h1:    scaleIndex = {value[30:0], 1'b0};
        2'h2:    scaleIndex = {value[29:0], 2'h0};
        default: scaleIndex = {value[28:0], 3'h0};
      endcase
    end
  endfunction

  // Byte lane mask for a size, before alignment
  function [6:0] sizeMask;
    input [1:0] size;
    begin
      case (size)
        `AGU_SIZE_BYTE: sizeMask = 7'h01;
        `AGU_SIZE_WORD: sizeMask = 7'h03;
        default:        sizeMask = 7'h0F;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Segment cache storage
  // --------------------------------------------------------------------
  reg  [15:0]          segSelector_q [0:NUM_SEGS-1];  // Visible selector
  reg  [31:0]          segBase_q     [0:NUM_SEGS-1];  // Cached base
  reg  [19:0]          segLimit_q    [0:NUM_SEGS-1];  // Cached limit
  reg  [3:0]           segType_q     [0:NUM_SEGS-1];  // Cached type

  reg  [1:0]           state_q;                       // Controller state
  reg  [SEG_SEL_W-1:0] pendSeg_q;                     // Segment awaiting fill

  // --------------------------------------------------------------------
  // Offset datapath
  // --------------------------------------------------------------------
  wire        indexOk;       // Index present and legal
  wire [31:0] baseTerm;      // Base term or zero
  wire [31:0] indexTerm;     // Scaled index term or zero
  wire [31:0] dispTerm;      // Displacement term or zero
  wire [31:0] offSum;        // Three-term sum, carry dropped
  wire        realPath;      // Real or virtual 8086 formation
  wire [31:0] activeOff;     // Offset at the active width
  wire [31:0] segBaseNow;    // Base of selected segment
  wire [19:0] realAddr;      // 20-bit real mode result
  wire [31:0] linearNow;     // Linear address of this request
  wire        pageNow;       // Request goes through paging
  wire [6:0]  laneMask;      // Byte lanes after alignment

  // Stack pointer code never serves as an index
  assign indexOk = useIndex && (indexSel != `AGU_SP_CODE);
  // Any general register may be the base
  assign baseTerm = useBase ? pickReg(genRegFile, baseSel) : 32'h0000_0000;
  // Scaling is applied before summation
  assign indexTerm = indexOk ?
                     scaleIndex(pickReg(genRegFile, indexSel), scaleMultiplier) :
                     32'h0000_0000;
  assign dispTerm = useDisp ? instructionDisplacement : 32'h0000_0000;
  // Presence flags cover all eight forms with one adder chain
  assign offSum = baseTerm + indexTerm + dispTerm;

  // Mode selects the formation path in the same cycle
  assign realPath = (opMode == `AGU_MODE_REAL) || (opMode == `AGU_MODE_V86);
  // Real paths keep 16 offset bits, protected keeps 32
  assign activeOff = realPath ? {16'h0000, offSum[15:0]} : offSum;

  // Cached base of the segment this request names
  assign segBaseNow = segBase_q[segSel];
  // Segment value times 16 plus offset, held to 20 bits
  assign realAddr = segSelector_q[segSel] * 20'h0_0010
                    + {4'h0, activeOff[15:0]};
  // Real: zero-extend 20 bits; protected: cached descriptor base
  assign linearNow = realPath ? {12'h000, realAddr} :
                     segBaseNow + activeOff;
  // Paging only applies outside real mode
  assign pageNow = pagingOn && (opMode != `AGU_MODE_REAL) && !reqIsIo;

  // Lanes counted upward from the least significant byte
  assign laneMask = sizeMask(accessSize) << activeOff[1:0];

  // --------------------------------------------------------------------
  // Descriptor fetch address
  // --------------------------------------------------------------------
  wire [31:0] tableBase;     // Table picked by the select bit
  wire [31:0] entryAddr;     // Eight-byte entry address

  // Select bit zero means global, one means local
  assign tableBase = segWriteValue[`AGU_SEL_TI_BIT] ?
                     localDescriptorTable : globalDescriptorTable;
  // 13-bit index scaled by the eight-byte entry size
  assign entryAddr = tableBase +
                     {16'h0000, segWriteValue[15:`AGU_SEL_IDX_LO], 3'h0};

  // --------------------------------------------------------------------
  // Acceptance
  // --------------------------------------------------------------------
  wire idle;        // Controller free
  wire takeSeg;     // Segment load accepted
  wire takeReq;     // Address request accepted
  wire protLoad;    // Segment load needs a descriptor

  assign idle     = (state_q == ST_IDLE);
  assign takeSeg  = idle && segWrite;
  assign takeReq  = idle && reqValid && !segWrite;
  // Every mode outside the real paths fetches a descriptor on a load,
  // so the spare mode code 3 loads and forms addresses as protected mode
  assign protLoad = !realPath;

  // --------------------------------------------------------------------
  // Segment cache entries
  // --------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_SEGS; g = g + 1) begin : segEntry
      // Entry loads on a selector write and on descriptor return
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          segSelector_q[g] <= 16'h0000;
          segBase_q[g]     <= 32'h0000_0000;
          segLimit_q[g]    <= 20'h0_FFFF;
          segType_q[g]     <= 4'h0;
        end else if (takeSeg && segWriteSel == g) begin
          // Selector kept; in real paths the base follows it directly
          segSelector_q[g] <= segWriteValue;
          if (!protLoad) begin
            segBase_q[g] <= {12'h000, segWriteValue, 4'h0};
          end
        end else if (state_q == ST_DESC && descValid && pendSeg_q == g) begin
          // Base assembled from the three descriptor base fields
          segBase_q[g] <= {descData[`AGU_DESC_BASE_HI_H:`AGU_DESC_BASE_HI_L],
                           descData[`AGU_DESC_BASE_MD_H:`AGU_DESC_BASE_MD_L],
                           descData[`AGU_DESC_BASE_LO_H:`AGU_DESC_BASE_LO_L]};
          segLimit_q[g] <= {descData[`AGU_DESC_LIM_HI_H:`AGU_DESC_LIM_HI_L],
                            descData[`AGU_DESC_LIM_LO_H:0]};
          segType_q[g]  <= descData[`AGU_DESC_TYPE_H:`AGU_DESC_TYPE_L];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Controller
  // --------------------------------------------------------------------
  reg [1:0] state_d;    // Next state

  // Next state selection
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (takeSeg && protLoad) begin
          state_d = ST_DESC;
        end else if (takeReq && pageNow) begin
          state_d = ST_PAGE;
        end
      end
      ST_PAGE: begin
        if (xlateDone) begin
          state_d = ST_IDLE;
        end
      end
      ST_DESC: begin
        if (descValid) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register and pending segment
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= ST_IDLE;
      pendSeg_q <= {SEG_SEL_W{1'b0}};
    end else begin
      state_q <= state_d;
      if (takeSeg) begin
        pendSeg_q <= segWriteSel;
      end
    end
  end

  // --------------------------------------------------------------------
  // Descriptor request outputs
  // --------------------------------------------------------------------

  // Fetch is raised only on protected selector loads
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      descReq  <= 1'b0;
      descAddr <= 32'h0000_0000;
    end else if (takeSeg && protLoad) begin
      // Cached copy is refreshed only here, never per access
      descReq  <= 1'b1;
      descAddr <= entryAddr;
    end else if (state_q == ST_DESC && descValid) begin
      descReq <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Address outputs
  // --------------------------------------------------------------------

  // Result registers, paging handshake and busy flag
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      addrValid       <= 1'b0;
      isIoAccess      <= 1'b0;
      physAddr        <= 32'h0000_0000;
      byteEnable      <= 4'h0;
      crossesDword    <= 1'b0;
      effectiveOffset <= 32'h0000_0000;
      linearAddr      <= 32'h0000_0000;
      xlateReq        <= 1'b0;
      busy            <= 1'b0;
    end else begin
      addrValid <= 1'b0;
      busy      <= (state_d != ST_IDLE);
      if (takeReq) begin
        effectiveOffset <= activeOff;
        byteEnable      <= laneMask[3:0];
        crossesDword    <= |laneMask[6:4];
        isIoAccess      <= reqIsIo;
        if (reqIsIo) begin
          // Port address is the low 16 offset bits; never a high window
          linearAddr <= activeOff & `AGU_IO_ADDR_MASK;
          physAddr   <= activeOff & `AGU_IO_ADDR_MASK;
          addrValid  <= 1'b1;
        end else if (pageNow) begin
          // Linear address handed to translation first
          linearAddr <= linearNow;
          xlateReq   <= 1'b1;
        end else begin
          // Without paging the linear address is physical, all 32 bits
          linearAddr <= linearNow;
          physAddr   <= linearNow;
          addrValid  <= 1'b1;
        end
      end else if (state_q == ST_PAGE && xlateDone) begin
        // Frame replaces upper bits; page offset passes unchanged
        physAddr  <= {xlateFrame, linearAddr[`AGU_PAGE_OFF_W-1:0]};
        xlateReq  <= 1'b0;
        addrValid <= 1'b1;
      end
    end
  end

endmodule

/* logic/agu_defs.vh */
`ifndef AGU_DEFS_VH
`define AGU_DEFS_VH

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define AGU_MODE_REAL      2'h0
`define AGU_MODE_V86       2'h1
`define AGU_MODE_PROT      2'h2

// ----------------------------------------------------------------------
// Access sizes
// ----------------------------------------------------------------------
`define AGU_SIZE_BYTE      2'h0
`define AGU_SIZE_WORD      2'h1
`define AGU_SIZE_DWORD     2'h2

// ----------------------------------------------------------------------
// Register codes and address constants
// ----------------------------------------------------------------------
`define AGU_SP_CODE        3'h4
`define AGU_REAL_ADDR_W    20
`define AGU_PAGE_OFF_W     12
`define AGU_IO_ADDR_MASK   32'h0000_FFFF
`define AGU_DESC_BYTES_LOG 3
`define AGU_SEL_TI_BIT     2
`define AGU_SEL_IDX_LO     3

// ----------------------------------------------------------------------
// Descriptor field positions
// ----------------------------------------------------------------------
`define AGU_DESC_BASE_LO_H 31
`define AGU_DESC_BASE_LO_L 16
`define AGU_DESC_BASE_MD_H 39
`define AGU_DESC_BASE_MD_L 32
`define AGU_DESC_BASE_HI_H 63
`define AGU_DESC_BASE_HI_L 56
`define AGU_DESC_LIM_LO_H  15
`define AGU_DESC_LIM_HI_H  51
`define AGU_DESC_LIM_HI_L  48
`define AGU_DESC_TYPE_H    43
`define AGU_DESC_TYPE_L    40

`endif

/* testbench/address_generation_unit_sva.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module address_generation_unit_sva (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [1:0]  opMode,
  input wire logic        pagingOn,
  input wire logic        reqValid,
  input wire logic        reqIsIo,
  input wire logic        segWrite,
  input wire logic [15:0] segWriteValue,
  input wire logic [31:0] globalDescriptorTable,
  input wire logic [31:0] localDescriptorTable,
  input wire logic        descValid,
  input wire logic        xlateDone,
  input wire logic [19:0] xlateFrame,
  input wire logic        busy,
  input wire logic        addrValid,
  input wire logic        isIoAccess,
  input wire logic [31:0] physAddr,
  input wire logic [3:0]  byteEnable,
  input wire logic [31:0] effectiveOffset,
  input wire logic [31:0] linearAddr,
  input wire logic        xlateReq,
  input wire logic        descReq,
  input wire logic [31:0] descAddr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Non-I/O request accepted at this edge
  wire take = reqValid && !busy && !segWrite && !reqIsIo;
  // Selector fields seen by the descriptor fetch check
  wire        selTableBit = segWriteValue[2];
  wire [12:0] selIndex    = segWriteValue[15:3];

  AST_IO_WINDOW: assert property (addrValid && isIoAccess |->
    physAddr == (effectiveOffset & 32'h0000_FFFF)) else $error("io address out of window");
  AST_REAL_REACH: assert property (take && opMode == 2'h0 |=> addrValid &&
    physAddr[31:20] == 12'h000 && effectiveOffset[31:16] == 16'h0000)
    else $error("real mode address too wide");
  AST_PROT_DIRECT: assert property (take && opMode[1] && !pagingOn |=>
    addrValid && physAddr == linearAddr) else $error("unpaged linear not used directly");
  AST_XLATE_RAISE: assert property (take && opMode != 2'h0 && pagingOn |=>
    xlateReq && busy && !addrValid) else $error("paging not requested");
  AST_XLATE_DONE: assert property (xlateReq && xlateDone |=> addrValid && !xlateReq &&
    physAddr == {$past(xlateFrame), linearAddr[11:0]}) else $error("page result wrong");
  AST_LOW_LANE: assert property (addrValid |-> byteEnable[effectiveOffset[1:0]])
    else $error("lowest byte lane not enabled");
  AST_DESC_FETCH: assert property (segWrite && !busy && opMode[1] |=> descReq && busy &&
    descAddr == ($past(selTableBit) ? $past(localDescriptorTable)
    : $past(globalDescriptorTable)) + {16'h0000, $past(selIndex), 3'h0})
    else $error("descriptor fetch address wrong");
  AST_DESC_DONE: assert property (descReq && descValid |=> !descReq && !busy)
    else $error("descriptor wait not closed");
endmodule

bind address_generation_unit address_generation_unit_sva uSva (
  .ref_clk(ref_clk), .rstn(rstn), .opMode(opMode), .pagingOn(pagingOn),
  .reqValid(reqValid), .reqIsIo(reqIsIo), .segWrite(segWrite), .segWriteValue(segWriteValue),
  .globalDescriptorTable(globalDescriptorTable), .localDescriptorTable(localDescriptorTable),
  .descValid(descValid), .xlateDone(xlateDone), .xlateFrame(xlateFrame), .busy(busy),
  .addrValid(addrValid), .isIoAccess(isIoAccess), .physAddr(physAddr),
  .byteEnable(byteEnable), .effectiveOffset(effectiveOffset), .linearAddr(linearAddr),
  .xlateReq(xlateReq), .descReq(descReq), .descAddr(descAddr));

/* testbench/address_generation_unit_tb_top.sv */
`timescale 1ns/1ps
`include "agu_defs.vh"
module address_generation_unit_tb_top;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic        ref_clk, rstn, pagingOn, reqValid, reqIsIo, useBase, useIndex, useDisp;
  logic        segWrite, descValid, xlateDone, busy, addrValid, isIoAccess, crossesDword;
  logic        xlateReq, descReq;
  logic [1:0]  opMode, scaleMultiplier, accessSize;
  logic [2:0]  baseSel, indexSel, segSel, segWriteSel;
  logic [3:0]  byteEnable;
  logic [15:0] segWriteValue;
  logic [19:0] xlateFrame;
  logic [31:0] instructionDisplacement, globalDescriptorTable, localDescriptorTable;
  logic [31:0] physAddr, effectiveOffset, linearAddr, descAddr;
  logic [63:0] descData;
  logic [255:0] genRegFile;
  logic [31:0] segB [0:7];  // Model of cached segment bases
  logic [31:0] regs [0:7];  // Model of general registers
  int          nFail = 0;
  int          checkCount = 0;

  address_generation_unit uut (
    .ref_clk(ref_clk), .rstn(rstn), .opMode(opMode), .pagingOn(pagingOn),
    .reqValid(reqValid), .reqIsIo(reqIsIo), .baseSel(baseSel), .indexSel(indexSel),
    .useBase(useBase), .useIndex(useIndex), .useDisp(useDisp),
    .scaleMultiplier(scaleMultiplier), .instructionDisplacement(instructionDisplacement),
    .accessSize(accessSize), .segSel(segSel), .genRegFile(genRegFile), .segWrite(segWrite),
    .segWriteSel(segWriteSel), .segWriteValue(segWriteValue),
    .globalDescriptorTable(globalDescriptorTable), .localDescriptorTable(localDescriptorTable),
    .descValid(descValid), .descData(descData), .xlateDone(xlateDone),
    .xlateFrame(xlateFrame), .busy(busy), .addrValid(addrValid), .isIoAccess(isIoAccess),
    .physAddr(physAddr), .byteEnable(byteEnable), .crossesDword(crossesDword),
    .effectiveOffset(effectiveOffset), .linearAddr(linearAddr), .xlateReq(xlateReq),
    .descReq(descReq), .descAddr(descAddr));

  // 40 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checkCount++;
    if (g !== e) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run
  task testDone;
    $display("checks %0d mismatches %0d", checkCount, nFail);
    if (nFail == 0 && checkCount > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Load one segment; protected path answers the descriptor fetch after a stall
  task segLoad(input logic [1:0] m, input logic [2:0] s);
    logic [15:0] v;
    logic [31:0] b, tbl;
    logic [63:0] d;
    v = 16'($urandom);
    if (m == 2'h1) v[15] = 1'b0;  // Keeps v86 sums below the 1 MB wrap
    b = $urandom;
    b[1:0] = 2'h0;  // Aligned base keeps byte lanes mode independent
    d = {$urandom, $urandom};
    d[63:56] = b[31:24];
    d[39:32] = b[23:16];
    d[31:16] = b[15:0];
    @(posedge ref_clk);
    opMode <= m; segWrite <= 1'b1; segWriteSel <= s; segWriteValue <= v;
    @(posedge ref_clk);
    segWrite <= 1'b0;
    if (m[1]) begin
      #1;
      tbl = v[2] ? localDescriptorTable : globalDescriptorTable;
      chk("descReq", 32'h1, descReq);
      chk("descAddr", tbl + {v[15:3], 3'h0}, descAddr);
      repeat ($urandom_range(1, 3)) @(posedge ref_clk);
      descValid <= 1'b1; descData <= d;
      @(posedge ref_clk);
      descValid <= 1'b0;
      #1 chk("descBusy", 32'h0, busy);
      segB[s] = b;
    end else segB[s] = {12'h000, v, 4'h0};
  endtask

  // One random address request compared with the model
  task doReq(input logic [1:0] m, input logic p, input logic [2:0] s);
    logic [31:0] off, lin, ph, d;
    logic [19:0] fr;
    logic [2:0]  bs, ix;
    logic [1:0]  sc, sz;
    logic        ub, ui, ud, io;
    logic [7:0]  mk;
    for (int k = 0; k < 8; k++) regs[k] = $urandom;
    {ub, ui, ud} = 3'($urandom);
    bs = 3'($urandom); ix = 3'($urandom); sc = 2'($urandom); sz = 2'($urandom_range(0, 2));
    d = $urandom; fr = 20'($urandom); io = ($urandom_range(0, 4) == 0);
    off = (ud ? d : 32'h0000_0000) + (ub ? regs[bs] : 32'h0000_0000)
        + ((ui && ix != `AGU_SP_CODE) ? regs[ix] << sc : 32'h0000_0000);
    if (!m[1]) off = off & 32'h0000_FFFF;
    lin = segB[s] + off;
    if (m == 2'h0) lin = lin & 32'h000F_FFFF;
    ph = (p && m != 2'h0) ? {fr, lin[11:0]} : lin;
    if (io) ph = off & 32'h0000_FFFF;
    mk = ((8'h01 << (sz == 2'h0 ? 1 : sz == 2'h1 ? 2 : 4)) - 8'h01) << off[1:0];
    @(posedge ref_clk);
    reqValid <= 1'b1; opMode <= m; pagingOn <= p; reqIsIo <= io; baseSel <= bs;
    indexSel <= ix; useBase <= ub; useIndex <= ui; useDisp <= ud; scaleMultiplier <= sc;
    instructionDisplacement <= d; accessSize <= sz; segSel <= s;
    genRegFile <= {regs[7], regs[6], regs[5], regs[4], regs[3], regs[2], regs[1], regs[0]};
    @(posedge ref_clk);
    reqValid <= 1'b0;
    #1;
    if (p && m != 2'h0 && !io) begin
      chk("xlateReq", 32'h1, xlateReq);
      repeat ($urandom_range(1, 3)) @(posedge ref_clk);
      xlateDone <= 1'b1; xlateFrame <= fr;
      @(posedge ref_clk);
      xlateDone <= 1'b0;
      #1;
    end
    chk("addrValid", 32'h1, addrValid);
    chk("isIo", {31'h0, io}, isIoAccess);
    chk("offset", off, effectiveOffset);
    chk("phys", ph, physAddr);
    if (!io) chk("linear", lin, linearAddr);
    chk("byteEnable", {28'h0, mk[3:0]}, byteEnable);
    chk("crossesDword", {31'h0, |mk[7:4]}, crossesDword);
  endtask

  // Main sequence: every mode with and without paging
  initial begin
    void'($urandom(32'hc6fb));
    {rstn, pagingOn, reqValid, reqIsIo, useBase, useIndex, useDisp, segWrite} = 8'h00;
    {descValid, xlateDone, opMode, scaleMultiplier, accessSize} = 8'h00;
    {baseSel, indexSel, segSel, segWriteSel, segWriteValue, xlateFrame} = 48'h0;
    {instructionDisplacement, descData, genRegFile} = 352'h0;
    globalDescriptorTable = $urandom;
    localDescriptorTable = $urandom;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      for (int p = 0; p < 2; p++) begin
        segSel <= 3'($urandom_range(0, 5));
        @(posedge ref_clk);
        segLoad(2'(m), segSel);
        repeat (12) doReq(2'(m), p[0], segSel);
      end
    end
    testDone;
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge ref_clk);
    nFail++;
    testDone;
  end
endmodule
